// ===== design/rx_byte_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Single clock domain; both sides on clk.
`timescale 1ns/100ps
module rx_byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rstn,
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output wire inReady,
	output wire outValid,
	output wire [WIDTH-1:0] outData,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wrPtr_reg;
	reg [AW:0] rdPtr_reg;
	wire full;
	wire empty;
	wire doPush;
	wire doPop;

	assign empty = (wrPtr_reg == rdPtr_reg);
	assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
	assign inReady = ~full;
	assign outValid = ~empty;
	assign outData = mem[rdPtr_reg[AW-1:0]];
	assign doPush = inValid & ~full;
	assign doPop = outReady & ~empty;

	always @(posedge clk) begin
		if (doPush) begin
			mem[wrPtr_reg[AW-1:0]] <= inData;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_reg <= {(AW+1){1'b0}};
			rdPtr_reg <= {(AW+1){1'b0}};
		end else begin
			if (doPush) begin
				wrPtr_reg <= wrPtr_reg + {{AW{1'b0}}, 1'b1};
			end
			if (doPop) begin
				rdPtr_reg <= rdPtr_reg + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

// ===== design/serial_flash_front_end.v
// Command front end of a serial flash: frames, decodes and shifts SPI traffic.
// The serial pins are asynchronous to clk and are oversampled; clk must run
// well above four times the serial clock. Data bytes in go to a FIFO.
//
// Notes on behaviour
// [RULE_01] Mode 0 or 3: sample on serial clock rise, drive on fall.
// [RULE_02] Host asserts select, then sends an 8-bit opcode, then address/data.
// [RULE_03] All bytes move most significant bit first, both directions.
// [RULE_04] Releasing select ends the command frame.
// [RULE_05] Unknown opcode starts nothing; input ignored until select re-asserts.
// [RULE_06] Select released before opcode and address complete: nothing happens.
// [RULE_07] Three address bytes arrive; top three address bits are dropped.
// [RULE_08] Dual input makes return line an input; dual output drives command line.
// [RULE_09] Erase opcodes 20h, 52h, D8h take three address bytes, no data.
// [RULE_10] Opcode 02h: three address bytes, then data bytes in on one line.
// [RULE_11] Opcode A2h: three address bytes, then data bytes on two lines.
// [RULE_12] Opcode 3Ch: three address bytes, no dummy, data bytes out.
// [RULE_13] Opcode 34h: three address bytes, exactly one data byte in.
// [RULE_14] Opcode 35h: three address bytes, no dummy, data bytes out.
// [RULE_15] Opcode 9Bh: three address bytes, then data bytes in.
// [RULE_16] Opcode 77h: three address bytes, two dummy bytes, then data out.
// [RULE_17] Opcode 01h: no address, exactly one data byte in.
// [RULE_18] Opcode 31h: no address, exactly one data byte in.
// [RULE_19] Opcode 9Fh: no address, identification bytes out; host clock limited.
// [RULE_20] Opcodes B9h and ABh take no address, dummy or data.
// [RULE_21] Reads: 1Bh two dummy bytes, 0Bh one, 03h none.
// [RULE_22] Opcode 3Bh: address, one dummy, two bits out per clock, high on return.
// [RULE_23] Select release during a read stops output at once, lines released.
`timescale 1ns/100ps
`include "flash_front_end_defs.vh"
module serial_flash_front_end (
	input wire clk,
	input wire rstn,
	input wire sck,
	input wire csN,
	input wire cmdLineIn,
	output wire cmdLineOut,
	output wire cmdLineOe,
	input wire returnLineIn,
	output wire returnLineOut,
	output wire returnLineOe,
	output wire cmdStart,
	output wire [7:0] cmdOpcode,
	output wire [`ADDR_W-1:0] cmdAddr,
	output wire frameEnd,
	input wire [7:0] txData,
	output wire txTake,
	output wire rxValid,
	output wire [7:0] rxData,
	input wire rxReady,
	output wire rxOverrun
);
	localparam [5:0] S_OPC = 6'h01;
	localparam [5:0] S_ADDR = 6'h02;
	localparam [5:0] S_DUMMY = 6'h04;
	localparam [5:0] S_DIN = 6'h08;
	localparam [5:0] S_DOUT = 6'h10;
	localparam [5:0] S_SKIP = 6'h20;

	// Opcode table: what follows each supported opcode
	function [7:0] decodeOp;
		input [7:0] op;
		begin
			case (op)
				`OP_READ_FAST2: decodeOp = `AT_ADDR_D2_OUT; // RULE_21
				`OP_READ_FAST1: decodeOp = `AT_ADDR_D1_OUT; // RULE_21
				`OP_READ_SLOW: decodeOp = `AT_ADDR_OUT; // RULE_21
				`OP_READ_DUAL: decodeOp = `AT_ADDR_D1_OUT_DUAL; // RULE_22
				`OP_ERASE_4K: decodeOp = `AT_ADDR_ONLY; // RULE_09
				`OP_ERASE_32K: decodeOp = `AT_ADDR_ONLY; // RULE_09
				`OP_ERASE_64K: decodeOp = `AT_ADDR_ONLY; // RULE_09
				`OP_CHIP_ERASE_A: decodeOp = `AT_PLAIN;
				`OP_CHIP_ERASE_B: decodeOp = `AT_PLAIN;
				`OP_PROGRAM: decodeOp = `AT_ADDR_IN; // RULE_10
				`OP_PROGRAM_DUAL: decodeOp = `AT_ADDR_IN_DUAL; // RULE_11
				`OP_SUSPEND: decodeOp = `AT_PLAIN;
				`OP_RESUME: decodeOp = `AT_PLAIN;
				`OP_WRITE_EN: decodeOp = `AT_PLAIN;
				`OP_WRITE_DIS: decodeOp = `AT_PLAIN;
				`OP_PROTECT: decodeOp = `AT_ADDR_ONLY;
				`OP_UNPROTECT: decodeOp = `AT_ADDR_ONLY;
				`OP_READ_PROT: decodeOp = `AT_ADDR_OUT; // RULE_12
				`OP_LOCKDOWN: decodeOp = `AT_ADDR_IN_ONE;
				`OP_FREEZE_LOCK: decodeOp = `AT_ADDR_IN_ONE; // RULE_13
				`OP_READ_LOCK: decodeOp = `AT_ADDR_OUT; // RULE_14
				`OP_OTP_PROGRAM: decodeOp = `AT_ADDR_IN; // RULE_15
				`OP_OTP_READ: decodeOp = `AT_ADDR_D2_OUT; // RULE_16
				`OP_READ_STATUS: decodeOp = `AT_OUT;
				`OP_WRITE_STAT1: decodeOp = `AT_IN_ONE; // RULE_17
				`OP_WRITE_STAT2: decodeOp = `AT_IN_ONE; // RULE_18
				`OP_SOFT_RESET: decodeOp = `AT_IN_ONE;
				`OP_READ_ID: decodeOp = `AT_OUT; // RULE_19
				`OP_POWER_DOWN: decodeOp = `AT_PLAIN; // RULE_20
				`OP_POWER_UP: decodeOp = `AT_PLAIN; // RULE_20
				default: decodeOp = `AT_NONE;
			endcase
		end
	endfunction

	// Phase that follows the header of a command
	function [5:0] dataPhase;
		input [7:0] at;
		begin
			if (at[`AT_DUMMY_HI:`AT_DUMMY_LO] != 2'd0) begin
				dataPhase = S_DUMMY;
			end else if (at[`AT_DIN]) begin
				dataPhase = S_DIN;
			end else if (at[`AT_DOUT]) begin
				dataPhase = S_DOUT;
			end else begin
				dataPhase = S_SKIP;
			end
		end
	endfunction

	// Two-stage synchronisers; stage one feeds only stage two
	reg sckMeta_reg, sckSync_reg, sckLast_reg;
	reg csMeta_reg, csSync_reg;
	reg cmdMeta_reg, cmdSync_reg;
	reg retMeta_reg, retSync_reg;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Reset high: a clock idling high gives no false rise after reset
			sckMeta_reg <= 1'b1;
			sckSync_reg <= 1'b1;
			sckLast_reg <= 1'b1;
			csMeta_reg <= 1'b1;
			csSync_reg <= 1'b1;
			cmdMeta_reg <= 1'b0;
			cmdSync_reg <= 1'b0;
			retMeta_reg <= 1'b0;
			retSync_reg <= 1'b0;
		end else begin
			sckMeta_reg <= sck;
			sckSync_reg <= sckMeta_reg;
			sckLast_reg <= sckSync_reg;
			csMeta_reg <= csN;
			csSync_reg <= csMeta_reg;
			cmdMeta_reg <= cmdLineIn;
			cmdSync_reg <= cmdMeta_reg;
			retMeta_reg <= returnLineIn;
			retSync_reg <= retMeta_reg;
		end
	end

	// Data pins pass the same stages as the clock, so they stay aligned
	wire sckRise = sckSync_reg & ~sckLast_reg; // RULE_01
	wire sckFall = ~sckSync_reg & sckLast_reg; // RULE_01
	wire csActive = ~csSync_reg;

	reg [5:0] phase_reg;
	reg [2:0] bitCnt_reg;
	reg [1:0] byteCnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] attr_reg;
	reg opActive_reg;
	reg cmdStart_reg;
	reg frameEnd_reg;
	reg [7:0] cmdOpcode_reg;
	reg [`ADDR_W-1:0] cmdAddr_reg;
	reg [7:0] outShift_reg;
	reg [2:0] outCnt_reg;
	reg retOut_reg;
	reg cmdOut_reg;
	reg txTake_reg;
	reg pushValid_reg;
	reg [7:0] pushData_reg;
	reg overrun_reg;
	wire fifoInReady;

	wire dualIn = (phase_reg == S_DIN) & attr_reg[`AT_DUAL];
	wire dualOut = (phase_reg == S_DOUT) & attr_reg[`AT_DUAL];
	// Dual input: return line carries the higher bit of each pair
	wire [7:0] inByte = dualIn ? {shift_reg[5:0], retSync_reg, cmdSync_reg} :
		{shift_reg[6:0], cmdSync_reg}; // RULE_03 RULE_08
	wire byteDone = dualIn ? (bitCnt_reg == 3'd6) : (bitCnt_reg == 3'd7);
	wire [7:0] opAttr = decodeOp(inByte);
	wire [7:0] outByte = (outCnt_reg == 3'd0) ? txData : outShift_reg;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg <= S_OPC;
			bitCnt_reg <= 3'd0;
			byteCnt_reg <= 2'd0;
			shift_reg <= 8'h00;
			attr_reg <= 8'h00;
			opActive_reg <= 1'b0;
			cmdStart_reg <= 1'b0;
			frameEnd_reg <= 1'b0;
			cmdOpcode_reg <= 8'h00;
			cmdAddr_reg <= {`ADDR_W{1'b0}};
			outShift_reg <= 8'h00;
			outCnt_reg <= 3'd0;
			retOut_reg <= 1'b0;
			cmdOut_reg <= 1'b0;
			txTake_reg <= 1'b0;
			pushValid_reg <= 1'b0;
			pushData_reg <= 8'h00;
		end else begin
			cmdStart_reg <= 1'b0;
			frameEnd_reg <= 1'b0;
			txTake_reg <= 1'b0;
			pushValid_reg <= 1'b0;
			if (!csActive) begin
				// Frame closed; a short frame never reached cmdStart
				phase_reg <= S_OPC; // RULE_04 RULE_06 RULE_23
				bitCnt_reg <= 3'd0;
				outCnt_reg <= 3'd0;
				opActive_reg <= 1'b0;
				frameEnd_reg <= opActive_reg; // RULE_04
			end else if (sckRise && phase_reg != S_SKIP && phase_reg != S_DOUT) begin
				shift_reg <= inByte;
				bitCnt_reg <= dualIn ? bitCnt_reg + 3'd2 : bitCnt_reg + 3'd1;
				if (byteDone) begin
					bitCnt_reg <= 3'd0;
					case (phase_reg)
						S_OPC: begin
							cmdOpcode_reg <= inByte; // RULE_02
							attr_reg <= opAttr;
							byteCnt_reg <= opAttr[`AT_DUMMY_HI:`AT_DUMMY_LO];
							if (!opAttr[`AT_VALID]) begin
								phase_reg <= S_SKIP; // RULE_05
							end else if (opAttr[`AT_ADDR]) begin
								phase_reg <= S_ADDR;
								byteCnt_reg <= 2'd0;
							end else begin
								cmdStart_reg <= 1'b1;
								opActive_reg <= 1'b1;
								phase_reg <= dataPhase(opAttr);
							end
						end
						S_ADDR: begin
							// Shifting drops A23-A21 off the top
							cmdAddr_reg <= {cmdAddr_reg[`ADDR_W-9:0], inByte}; // RULE_07
							byteCnt_reg <= byteCnt_reg + 2'd1;
							if (byteCnt_reg == `ADDR_BYTES - 2'd1) begin
								cmdStart_reg <= 1'b1;
								opActive_reg <= 1'b1;
								phase_reg <= dataPhase(attr_reg);
								byteCnt_reg <= attr_reg[`AT_DUMMY_HI:`AT_DUMMY_LO];
							end
						end
						S_DUMMY: begin
							byteCnt_reg <= byteCnt_reg - 2'd1; // RULE_16 RULE_21
							if (byteCnt_reg == 2'd1) begin
								phase_reg <= attr_reg[`AT_DIN] ? S_DIN : S_DOUT;
							end
						end
						S_DIN: begin
							pushValid_reg <= 1'b1; // RULE_10 RULE_11 RULE_15
							pushData_reg <= inByte;
							if (attr_reg[`AT_ONE]) begin
								phase_reg <= S_SKIP; // RULE_13 RULE_17 RULE_18
							end
						end
						default: begin
							phase_reg <= S_SKIP;
						end
					endcase
				end
			end else if (sckFall && phase_reg == S_DOUT) begin
				// Byte fetched at its first falling edge, so txData needs
				// to be ready only at that point
				retOut_reg <= outByte[7]; // RULE_01 RULE_03
				if (attr_reg[`AT_DUAL]) begin
					cmdOut_reg <= outByte[6]; // RULE_22
					outShift_reg <= {outByte[5:0], 2'b00};
					outCnt_reg <= outCnt_reg + 3'd2;
				end else begin
					outShift_reg <= {outByte[6:0], 1'b0};
					outCnt_reg <= outCnt_reg + 3'd1;
				end
				txTake_reg <= (outCnt_reg == 3'd0);
			end
		end
	end

	// Overrun: host cannot be stalled, so a full FIFO loses the byte
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overrun_reg <= 1'b0;
		end else if (pushValid_reg && !fifoInReady) begin
			overrun_reg <= 1'b1;
		end else if (cmdStart_reg) begin
			overrun_reg <= 1'b0;
		end
	end

	rx_byte_fifo #(
		.WIDTH(`BYTE_W),
		.DEPTH(`RX_FIFO_DEPTH),
		.AW(`RX_FIFO_AW)
	) rxFifo (
		.clk(clk),
		.rstn(rstn),
		.inValid(pushValid_reg),
		.inData(pushData_reg),
		.inReady(fifoInReady),
		.outValid(rxValid),
		.outData(rxData),
		.outReady(rxReady)
	);

	// Output enables drop with the synced select, mid-byte if need be
	assign returnLineOe = csActive & (phase_reg == S_DOUT); // RULE_08 RULE_23
	assign cmdLineOe = csActive & dualOut; // RULE_08 RULE_22
	assign returnLineOut = retOut_reg;
	assign cmdLineOut = cmdOut_reg;
	assign cmdStart = cmdStart_reg;
	assign cmdOpcode = cmdOpcode_reg;
	assign cmdAddr = cmdAddr_reg;
	assign frameEnd = frameEnd_reg;
	assign txTake = txTake_reg;
	assign rxOverrun = overrun_reg;
endmodule

// ===== pkg/flash_front_end_defs.vh
// Constants for the serial flash command front end.
// Included by the front end; holds definitions only.
`ifndef FLASH_FRONT_END_DEFS_VH
`define FLASH_FRONT_END_DEFS_VH

// Array address kept after dropping the top three bits
`define ADDR_W 21
`define ADDR_BYTES 2'd3
`define BYTE_W 8
`define RX_FIFO_DEPTH 8
`define RX_FIFO_AW 3

// Host serial clock ceiling for the identification read, in MHz
`define ID_SCK_MAX_MHZ 85

// Opcodes
`define OP_READ_FAST2 8'h1b
`define OP_READ_FAST1 8'h0b
`define OP_READ_SLOW 8'h03
`define OP_READ_DUAL 8'h3b
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_PROGRAM 8'h02
`define OP_PROGRAM_DUAL 8'ha2
`define OP_SUSPEND 8'hb0
`define OP_RESUME 8'hd0
`define OP_WRITE_EN 8'h06
`define OP_WRITE_DIS 8'h04
`define OP_PROTECT 8'h36
`define OP_UNPROTECT 8'h39
`define OP_READ_PROT 8'h3c
`define OP_LOCKDOWN 8'h33
`define OP_FREEZE_LOCK 8'h34
`define OP_READ_LOCK 8'h35
`define OP_OTP_PROGRAM 8'h9b
`define OP_OTP_READ 8'h77
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STAT1 8'h01
`define OP_WRITE_STAT2 8'h31
`define OP_SOFT_RESET 8'hf0
`define OP_READ_ID 8'h9f
`define OP_POWER_DOWN 8'hb9
`define OP_POWER_UP 8'hab

// Attribute bit positions of a decoded opcode
`define AT_VALID 7
`define AT_ADDR 6
`define AT_DUMMY_HI 5
`define AT_DUMMY_LO 4
`define AT_DIN 3
`define AT_DOUT 2
`define AT_DUAL 1
`define AT_ONE 0

// Attribute patterns: valid, addr, dummy[1:0], in, out, dual, one
`define AT_NONE 8'h00
`define AT_PLAIN 8'h80
`define AT_ADDR_ONLY 8'hc0
`define AT_ADDR_IN 8'hc8
`define AT_ADDR_IN_DUAL 8'hca
`define AT_ADDR_IN_ONE 8'hc9
`define AT_ADDR_OUT 8'hc4
`define AT_ADDR_D1_OUT 8'hd4
`define AT_ADDR_D1_OUT_DUAL 8'hd6
`define AT_ADDR_D2_OUT 8'he4
`define AT_OUT 8'h84
`define AT_IN_ONE 8'h89

`endif

// ===== test/flash_front_end_assertions.sv
// Checker on the flash front end's ports.
// Bound to serial_flash_front_end from the bench top; one clock domain.
`timescale 1ns/100ps
module flash_front_end_assertions (
	input wire clk,
	input wire rstn,
	input wire sck,
	input wire csN,
	input wire cmdLineOut,
	input wire cmdLineOe,
	input wire returnLineOut,
	input wire returnLineOe,
	input wire cmdStart,
	input wire frameEnd,
	input wire txTake,
	input wire rxValid,
	input wire [7:0] rxData,
	input wire rxReady
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	oe_release_a: assert property ($rose(csN) |-> ##[1:6] !returnLineOe && !cmdLineOe)
		else $error("line enable held after deselect");
	oe_idle_a: assert property (csN [*8] |-> !returnLineOe && !cmdLineOe)
		else $error("line driven while deselected");
	dual_oe_a: assert property (cmdLineOe |-> returnLineOe)
		else $error("command line driven outside dual read");
	start_sel_a: assert property (cmdStart |-> !csN ##1 !cmdStart)
		else $error("start outside a frame or too long");
	end_sel_a: assert property (frameEnd |-> csN && $past(csN, 2) ##1 !frameEnd)
		else $error("frame end without deselect");
	idle_start_a: assert property (csN [*4] |-> !cmdStart && !txTake)
		else $error("activity while deselected");
	out_fall_a: assert property ((returnLineOe && $changed(returnLineOut))
		|| (cmdLineOe && $changed(cmdLineOut)) |-> !sck)
		else $error("output moved while serial clock high");
	take_fall_a: assert property (txTake |-> !sck && returnLineOe ##1 !txTake)
		else $error("byte taken off a falling edge");
	fifo_hold_a: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
		else $error("queued byte lost or changed");
endmodule

// ===== test/serial_flash_front_end_tb.sv
// Bench for the flash front end: host model, random and corner frames.
// Needs host model, checker and design compiled first.
`timescale 1ns/100ps
`include "flash_front_end_defs.vh"
module serial_flash_front_end_tb;
	reg clk = 0;
	reg rstn = 0;
	reg [7:0] txData = 0;
	reg rxReady = 0;
	wire sck, csN, mosi, miso, hostOe, cmdLineOut, cmdLineOe, returnLineOut, returnLineOe;
	wire cmdStart, frameEnd, txTake, rxValid, rxOverrun;
	wire [7:0] cmdOpcode, rxData;
	wire [`ADDR_W-1:0] cmdAddr;
	// Released return line shows the inverse of the device's last output bit
	wire cmdIn = cmdLineOe ? cmdLineOut : mosi;
	wire retIn = returnLineOe ? returnLineOut : hostOe ? miso : ~returnLineOut;
	integer n_mismatch = 0, n_tests = 0, nClk = 0, nStart = 0, nEnd = 0, nTake = 0, i, j, k, s, t;
	reg [7:0] q, r, gotOp;
	reg [`ADDR_W-1:0] gotAddr;
	reg [23:0] a;
	reg [15:0] e;
	reg [31:0] exp [$];
	reg [8:0] dec [0:29] = '{9'h11b, 9'h10b, 9'h103, 9'h13b, 9'h120, 9'h152, 9'h1d8, 9'h060,
		9'h0c7, 9'h102, 9'h1a2, 9'h0b0, 9'h0d0, 9'h006, 9'h004, 9'h136, 9'h139, 9'h13c, 9'h133,
		9'h134, 9'h135, 9'h19b, 9'h177, 9'h005, 9'h001, 9'h031, 9'h0f0, 9'h09f, 9'h0b9, 9'h0ab};
	// Bytes sent, one-byte, dual, address, opcode
	reg [15:0] prg [0:5] = '{16'ha202,
		16'h36a2, 16'h229b,
		16'h2801, 16'h2831,
		16'h2a34};
	// Dual, address, dummy count, opcode
	reg [11:0] rd [0:7] = '{12'h50b, 12'h403, 12'h61b,
		12'h677, 12'h43c, 12'h435,
		12'h09f, 12'hd3b};
	always #2 clk = ~clk;
	spi_host_model spi_host_model_i (.clk(clk), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso),
		.hostOe(hostOe), .cmdLineOut(cmdLineOut), .returnLineOut(returnLineOut),
		.returnLineOe(returnLineOe));
	serial_flash_front_end serial_flash_front_end_i (.clk(clk), .rstn(rstn), .sck(sck),
		.csN(csN), .cmdLineIn(cmdIn), .cmdLineOut(cmdLineOut), .cmdLineOe(cmdLineOe),
		.returnLineIn(retIn), .returnLineOut(returnLineOut), .returnLineOe(returnLineOe),
		.cmdStart(cmdStart), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .frameEnd(frameEnd),
		.txData(txData), .txTake(txTake), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .rxOverrun(rxOverrun));
	always @(posedge clk) begin
		nClk <= nClk + 1;
		if (cmdStart) begin
			nStart <= nStart + 1;
			gotOp <= cmdOpcode;
			gotAddr <= cmdAddr;
		end
		if (frameEnd)
			nEnd <= nEnd + 1;
		if (txTake)
			nTake <= nTake + 1;
		if (nClk == 80000) begin
			n_mismatch = n_mismatch + 1;
			results;
		end
	end
	task results;
		begin
			if (n_mismatch == 0 && n_tests > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] x);
		begin
			n_tests = n_tests + 1;
			if (g !== x) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
			end
		end
	endtask
	task cmd(input [7:0] op, input ad, input m);
		begin
			a = 24'($urandom);
			spi_host_model_i.sel(m);
			spi_host_model_i.xfer(op, 0, r);
			if (ad)
				for (k = 2; k >= 0; k = k - 1)
					spi_host_model_i.xfer(a[8*k +: 8], 0, r);
		end
	endtask
	task drain;
		begin
			@(posedge clk);
			rxReady <= 1;
			repeat (40) begin
				@(negedge clk);
				if (rxValid === 1'b1 && rxReady)
					chk(rxData, exp.size() ? exp.pop_front() : 32'h1ff);
			end
			@(posedge clk);
			rxReady <= 0;
			chk(exp.size(), 0);
		end
	endtask
	initial begin
		i = $urandom(78718);
		repeat (4) @(posedge clk);
		rstn <= 1;
		@(negedge clk);
		chk({cmdStart, frameEnd, txTake, rxValid, cmdLineOe, returnLineOe, rxOverrun}, 0);
		for (i = 0; i < 30; i = i + 1) begin
			j = nStart;
			s = nEnd;
			cmd(dec[i][7:0], dec[i][8], i[0]);
			spi_host_model_i.desel;
			chk(nStart, j + 1);
			chk(gotOp, dec[i][7:0]);
			if (dec[i][8])
				chk(gotAddr, a[20:0]);
			chk(nEnd, s + 1);
		end
		j = nStart;
		s = nEnd;
		cmd(8'h5a, 1, 0);
		spi_host_model_i.xfer(8'h06, 0, r);
		spi_host_model_i.desel;
		chk(nStart, j);
		chk(nEnd, s);
		cmd(8'h02, 0, 1);
		spi_host_model_i.xfer(8'h12, 0, r);
		spi_host_model_i.xfer(8'h34, 0, r);
		spi_host_model_i.desel;
		chk(nStart, j);
		chk(nEnd, s);
		for (i = 0; i < 6; i = i + 1) begin
			e = prg[i];
			cmd(e[7:0], e[9], 0);
			for (j = 0; j < e[15:12]; j = j + 1) begin
				q = 8'($urandom);
				if (j < 8 && !(e[11] && j > 0))
					exp.push_back(q);
				spi_host_model_i.xfer(q, e[10], r);
			end
			spi_host_model_i.desel;
			chk(rxOverrun, e[15:12] > 8);
			drain;
		end
		for (i = 0; i < 8; i = i + 1) begin
			e = rd[i];
			t = nTake;
			@(posedge clk);
			txData <= 8'($urandom);
			cmd(e[7:0], e[10], i[0]);
			repeat (e[9:8]) spi_host_model_i.xfer(8'h00, 0, r);
			spi_host_model_i.xfer(8'hff, e[11], r);
			spi_host_model_i.desel;
			chk(r, txData);
			chk(nTake, t + 2 - i[0]);
		end
		results;
	end
endmodule
bind serial_flash_front_end flash_front_end_assertions flash_front_end_assertions_i (
	.clk(clk), .rstn(rstn), .sck(sck), .csN(csN), .cmdLineOut(cmdLineOut),
	.cmdLineOe(cmdLineOe), .returnLineOut(returnLineOut), .returnLineOe(returnLineOe),
	.cmdStart(cmdStart), .frameEnd(frameEnd), .txTake(txTake), .rxValid(rxValid),
	.rxData(rxData), .rxReady(rxReady));

// ===== test/spi_host_model.sv
// SPI host model: select, serial clock and lines, mode 0 or 3.
// Tasks are called from one bench process; all moves follow a clk rise.
`timescale 1ns/100ps
module spi_host_model (
	input wire clk,
	output reg sck,
	output reg csN,
	output reg mosi,
	output reg miso,
	output reg hostOe,
	input wire cmdLineOut,
	input wire returnLineOut,
	input wire returnLineOe
);
	reg idle;
	initial begin
		sck = 0;
		csN = 1;
		mosi = 0;
		miso = 0;
		hostOe = 0;
		idle = 0;
	end
	task sel(input m);
		begin
			idle = m;
			@(posedge clk);
			sck <= m;
			repeat (20) @(posedge clk);
			csN <= 0;
			repeat (20) @(posedge clk);
		end
	endtask
	// Dual moves two bits per clock, higher one on the return line
	task xfer(input [7:0] d, input dual, output [7:0] r);
		reg [7:0] s;
		begin
			s = d;
			r = 0;
			// Host lets go of the return line while the device drives it
			hostOe <= dual & ~returnLineOe;
			repeat (dual ? 4 : 8) begin
				@(posedge clk);
				sck <= 0;
				mosi <= dual ? s[6] : s[7];
				miso <= s[7];
				s = s << (1 + dual);
				repeat (20) @(posedge clk);
				sck <= 1;
				r = (r << (1 + dual)) | (dual ? {returnLineOut, cmdLineOut} : {1'b0, returnLineOut});
				repeat (19) @(posedge clk);
			end
		end
	endtask
	task desel;
		begin
			@(posedge clk);
			sck <= idle;
			hostOe <= 0;
			repeat (20) @(posedge clk);
			csN <= 1;
			repeat (20) @(posedge clk);
		end
	endtask
endmodule
